// File: hw/acr_adc_control.sv
// Register and sequencing logic of an eight-channel 10-bit converter.
// Assumes an APB master on CLK_I and a converter core that holds SAMPLE_RESULT_I
// valid while CONV_ACTIVE_O is high; OSC_CLK_I is sampled as a synchronous level.
`timescale 1ns/1ps

// How it works
// - Flag set per conversion, software cannot write
// - Control writes and low reads clear flag
// - Flag reads zero while interrupts enabled
// - Interrupt raised at each conversion end
// - Result read or control write drops interrupt
// - Reset clears flag, interrupt enable, continuous
// - Continuous mode reconverts and rewrites result
// - Single mode converts once then stops
// - Five-bit select, codes 0-7 port pins
// - Auto-scan takes channel from scan counter
// - Codes 29, 30 references; 31 powers off
// - Reserved codes give undefined results
// - Three-bit prescaler divides by 1 to 16
// - Source bit picks bus or oscillator
// - Two-bit justification field, reset right justified
// - Control write starts 16-17 cycle conversion
// - Result placed per justification mode
// - High read locks low byte until read
// - Status/control write resets scan counter to zero
module acr_adc_control (
  // Clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RESET_I,
  // APB slave
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [acr_pkg::ADDR_W-1:0]  PADDR_I,
  input  wire logic [acr_pkg::DATA_W-1:0]  PWDATA_I,
  output logic      [acr_pkg::DATA_W-1:0]  PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  // Converter core
  input  wire logic                        OSC_CLK_I,
  input  wire logic [9:0]                  SAMPLE_RESULT_I,
  output logic      [4:0]                  CHANNEL_O,
  output logic                             POWER_DOWN_O,
  output logic                             CONV_ACTIVE_O,
  output logic                             CONV_TICK_O,
  // Interrupt request
  output logic                             IRQ_O
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic hit(input logic [acr_pkg::ADDR_W-1:0] addr,
                               input logic [7:0]                 idx);
    return addr == acr_pkg::reg_addr(idx);
  endfunction

  // Last prescaler count for a divide code
  function automatic logic [3:0] presc_last(input logic [2:0] code);
    logic [3:0] last;
    last = 4'hF;
    unique case (code)
      3'h0:    last = 4'h0;
      3'h1:    last = 4'h1;
      3'h2:    last = 4'h3;
      3'h3:    last = 4'h7;
      default: last = 4'hF;
    endcase
    return last;
  endfunction

  // Placement of a sample in the result pair
  function automatic acr_pkg::acr_result_t place(input logic [9:0]         s,
                                                 input acr_pkg::acr_just_t m);
    acr_pkg::acr_result_t r;
    r = acr_pkg::RES_RST;
    unique case (m)
      acr_pkg::JUST_TRUNC: r = '{8'h00, s[9:2]};
      acr_pkg::JUST_RIGHT: r = '{{6'h00, s[9:8]}, s[7:0]};
      acr_pkg::JUST_LEFT:  r = '{s[9:2], {s[1:0], 6'h00}};
      acr_pkg::JUST_SIGN:  r = '{{~s[9], s[8:2]}, {s[1:0], 6'h00}};
    endcase
    return r;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  acr_pkg::acr_scr_t    scr_r,       scr_nxt;
  acr_pkg::acr_clk_t    clk_r,       clk_nxt;
  acr_pkg::acr_scan_t   scan_r,      scan_nxt;
  acr_pkg::acr_result_t res0_r,      res0_nxt;
  acr_pkg::acr_state_t  state_r,     state_nxt;
  logic [3:1][7:0]      scan_res_r,  scan_res_nxt;
  logic                 lock_r,      lock_nxt;
  logic [3:0]           presc_r,     presc_nxt;
  logic [4:0]           tick_r,      tick_nxt;
  logic [1:0]           scnt_r,      scnt_nxt;
  logic                 osc_prev_r;
  logic [31:0]          prdata_r,    prdata_nxt;
  logic [4:0]           chan_r,      chan_nxt;
  logic                 pdown_r,     pdown_nxt;
  logic                 ctick_r,     ctick_nxt;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic                 setup;
  logic                 access;
  logic                 mapped;
  logic                 wr_scr;
  logic                 wr_clk;
  logic                 wr_scan;
  logic                 rd_high0;
  logic                 rd_low0;
  logic                 rd_low_any;
  acr_pkg::acr_scr_t    wscr;

  assign setup  = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign mapped = hit(PADDR_I, acr_pkg::IDX_STATUS_CTRL) | hit(PADDR_I, acr_pkg::IDX_CLOCK_CTRL)
                | hit(PADDR_I, acr_pkg::IDX_RES_HIGH0) | hit(PADDR_I, acr_pkg::IDX_RES_LOW0)
                | hit(PADDR_I, acr_pkg::IDX_SCAN_RES1) | hit(PADDR_I, acr_pkg::IDX_SCAN_RES2)
                | hit(PADDR_I, acr_pkg::IDX_SCAN_RES3) | hit(PADDR_I, acr_pkg::IDX_SCAN_CTRL);
  assign wr_scr     = access & PWRITE_I & hit(PADDR_I, acr_pkg::IDX_STATUS_CTRL);
  assign wr_clk     = access & PWRITE_I & hit(PADDR_I, acr_pkg::IDX_CLOCK_CTRL);
  assign wr_scan    = access & PWRITE_I & hit(PADDR_I, acr_pkg::IDX_SCAN_CTRL);
  assign rd_high0   = access & ~PWRITE_I & hit(PADDR_I, acr_pkg::IDX_RES_HIGH0);
  assign rd_low0    = access & ~PWRITE_I & hit(PADDR_I, acr_pkg::IDX_RES_LOW0);
  assign rd_low_any = rd_low0 | (access & ~PWRITE_I & (hit(PADDR_I, acr_pkg::IDX_SCAN_RES1)
                    | hit(PADDR_I, acr_pkg::IDX_SCAN_RES2) | hit(PADDR_I, acr_pkg::IDX_SCAN_RES3)));
  assign wscr       = acr_pkg::acr_scr_t'(PWDATA_I[7:0]);

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access & ~mapped;
  assign PRDATA_O  = prdata_r;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic                 src_edge;
  logic                 adc_tick;
  logic                 conv_end;
  logic [4:0]           eff_chan;

  always_comb begin
    scr_nxt      = scr_r;
    clk_nxt      = clk_r;
    scan_nxt     = scan_r;
    res0_nxt     = res0_r;
    scan_res_nxt = scan_res_r;
    state_nxt    = state_r;
    lock_nxt     = lock_r;
    presc_nxt    = presc_r;
    tick_nxt     = tick_r;
    scnt_nxt     = scnt_r;
    prdata_nxt   = prdata_r;

    src_edge = clk_r.clock_source_select | (OSC_CLK_I & ~osc_prev_r);
    // divide by 1, 2, 4, 8 or 16
    adc_tick = (state_r == acr_pkg::ST_CONV) & src_edge
             & (presc_r == presc_last(clk_r.clock_prescale));
    conv_end = adc_tick & (tick_r == acr_pkg::CONV_LAST);
    eff_chan = scan_r.scan_enable ? {3'h0, scnt_r} : scr_r.channel_select;

    if (state_r == acr_pkg::ST_CONV && src_edge) begin
      presc_nxt = adc_tick ? 4'h0 : presc_r + 4'h1;
    end
    if (adc_tick) begin
      tick_nxt = tick_r + 5'h01;
    end

    // control writes and low reads clear flag
    if (wr_scr || wr_clk || rd_low_any) begin
      scr_nxt.conv_done_flag = 1'b0;
    end
    if (rd_high0 && scr_r.irq_enable) begin
      scr_nxt.conv_done_flag = 1'b0;
    end

    if (rd_low0) begin
      lock_nxt = 1'b0;
    end
    if (rd_high0 && clk_r.justify_sel != acr_pkg::JUST_TRUNC) begin
      lock_nxt = 1'b1;
    end

    if (conv_end) begin
      scr_nxt.conv_done_flag = 1'b1;
      tick_nxt               = 5'h00;
      if (scan_r.scan_enable && scnt_r != 2'h0) begin
        scan_res_nxt[scnt_r] = SAMPLE_RESULT_I[9:2];
      end else if (!lock_r || clk_r.justify_sel == acr_pkg::JUST_TRUNC) begin
        res0_nxt = place(SAMPLE_RESULT_I, clk_r.justify_sel);
      end
      if (scan_r.scan_enable) begin
        if (scnt_r != scan_r.scan_last) begin
          scnt_nxt = scnt_r + 2'h1;
        end else begin
          state_nxt = acr_pkg::ST_IDLE;
        end
      end else if (scr_r.continuous_convert && scr_r.channel_select != acr_pkg::CH_POWER_OFF) begin
        state_nxt = acr_pkg::ST_CONV;
      end else begin
        state_nxt = acr_pkg::ST_IDLE;
      end
    end

    if (wr_clk) begin
      clk_nxt  = acr_pkg::acr_clk_t'(PWDATA_I[7:0]);
      lock_nxt = 1'b0;
    end
    if (wr_scan) begin
      scan_nxt = acr_pkg::acr_scan_t'(PWDATA_I[7:0]);
    end
    if (wr_scr) begin
      scr_nxt.irq_enable         = wscr.irq_enable;
      scr_nxt.continuous_convert = wscr.continuous_convert;
      scr_nxt.channel_select     = wscr.channel_select;
      lock_nxt                   = 1'b0;
      scnt_nxt                   = 2'h0;
      if (scan_r.scan_enable || wscr.channel_select != acr_pkg::CH_POWER_OFF) begin
        state_nxt = acr_pkg::ST_CONV;
      end else begin
        state_nxt = acr_pkg::ST_IDLE;
      end
      presc_nxt = 4'h0;
      tick_nxt  = 5'h00;
    end

    // Read data captured in the setup cycle
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      if (!PWRITE_I) begin
        if (hit(PADDR_I, acr_pkg::IDX_STATUS_CTRL)) begin
          prdata_nxt[7:0] = {scr_r.conv_done_flag & ~scr_r.irq_enable, scr_r.irq_enable,
                             scr_r.continuous_convert, scr_r.channel_select};
        end
        if (hit(PADDR_I, acr_pkg::IDX_CLOCK_CTRL)) begin
          prdata_nxt[7:0] = {clk_r.clock_prescale, clk_r.clock_source_select,
                             clk_r.justify_sel, 2'h0};
        end
        if (hit(PADDR_I, acr_pkg::IDX_RES_HIGH0)) begin
          prdata_nxt[7:0] = res0_r.high;
        end
        if (hit(PADDR_I, acr_pkg::IDX_RES_LOW0)) begin
          prdata_nxt[7:0] = res0_r.low;
        end
        if (hit(PADDR_I, acr_pkg::IDX_SCAN_RES1)) begin
          prdata_nxt[7:0] = scan_res_r[1];
        end
        if (hit(PADDR_I, acr_pkg::IDX_SCAN_RES2)) begin
          prdata_nxt[7:0] = scan_res_r[2];
        end
        if (hit(PADDR_I, acr_pkg::IDX_SCAN_RES3)) begin
          prdata_nxt[7:0] = scan_res_r[3];
        end
        if (hit(PADDR_I, acr_pkg::IDX_SCAN_CTRL)) begin
          prdata_nxt[7:0] = {5'h00, scan_r.scan_enable, scan_r.scan_last};
        end
      end
    end
  end

  // ************************************************************
  // Converter-facing outputs
  // ************************************************************
  always_comb begin
    // references pass, top code powers off
    chan_nxt  = eff_chan;
    pdown_nxt = (eff_chan == acr_pkg::CH_POWER_OFF);
    ctick_nxt = adc_tick;
  end

  assign CHANNEL_O     = chan_r;
  assign POWER_DOWN_O  = pdown_r;
  assign CONV_ACTIVE_O = (state_r == acr_pkg::ST_CONV);
  assign CONV_TICK_O   = ctick_r;
  assign IRQ_O         = scr_r.conv_done_flag & scr_r.irq_enable;

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      scr_r      <= acr_pkg::SCR_RST;
      clk_r      <= acr_pkg::CLK_RST;
      scan_r     <= acr_pkg::SCAN_RST;
      res0_r     <= acr_pkg::RES_RST;
      scan_res_r <= '0;
      state_r    <= acr_pkg::ST_IDLE;
      lock_r     <= 1'b0;
      presc_r    <= 4'h0;
      tick_r     <= 5'h00;
      scnt_r     <= 2'h0;
      osc_prev_r <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      chan_r     <= acr_pkg::CH_POWER_OFF;
      pdown_r    <= 1'b1;
      ctick_r    <= 1'b0;
    end else begin
      scr_r      <= scr_nxt;
      clk_r      <= clk_nxt;
      scan_r     <= scan_nxt;
      res0_r     <= res0_nxt;
      scan_res_r <= scan_res_nxt;
      state_r    <= state_nxt;
      lock_r     <= lock_nxt;
      presc_r    <= presc_nxt;
      tick_r     <= tick_nxt;
      scnt_r     <= scnt_nxt;
      osc_prev_r <= OSC_CLK_I;
      prdata_r   <= prdata_nxt;
      chan_r     <= chan_nxt;
      pdown_r    <= pdown_nxt;
      ctick_r    <= ctick_nxt;
    end
  end

endmodule

// File: include/acr_pkg.sv
// Constants, register map, field layouts and types for the converter control block.
// Assumes a 32-bit APB host and a converter core that presents a 10-bit sample.
package acr_pkg;

  // ************************************************************
  // Bus geometry and register map
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_STATUS_CTRL = 8'h57;
  localparam logic [7:0] IDX_CLOCK_CTRL  = 8'h58;
  localparam logic [7:0] IDX_RES_HIGH0   = 8'h59;
  localparam logic [7:0] IDX_RES_LOW0    = 8'h5A;
  localparam logic [7:0] IDX_SCAN_RES1   = 8'h5B;
  localparam logic [7:0] IDX_SCAN_RES2   = 8'h5C;
  localparam logic [7:0] IDX_SCAN_RES3   = 8'h5D;
  localparam logic [7:0] IDX_SCAN_CTRL   = 8'h5E;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // ************************************************************
  // Field layouts
  // ************************************************************
  typedef enum logic [1:0] {
    JUST_TRUNC = 2'h0,
    JUST_RIGHT = 2'h1,
    JUST_LEFT  = 2'h2,
    JUST_SIGN  = 2'h3
  } acr_just_t;

  typedef struct packed {
    logic       conv_done_flag;
    logic       irq_enable;
    logic       continuous_convert;
    logic [4:0] channel_select;
  } acr_scr_t;

  typedef struct packed {
    logic [2:0] clock_prescale;
    logic       clock_source_select;
    acr_just_t  justify_sel;
    logic [1:0] unused;
  } acr_clk_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       scan_enable;
    logic [1:0] scan_last;
  } acr_scan_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acr_result_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } acr_state_t;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam acr_scr_t    SCR_RST  = '{1'h0, 1'h0, 1'h0, 5'h1F};
  localparam acr_clk_t    CLK_RST  = '{3'h0, 1'h0, JUST_RIGHT, 2'h0};
  localparam acr_scan_t   SCAN_RST = '{5'h00, 1'h0, 2'h0};
  localparam acr_result_t RES_RST  = '{8'h00, 8'h00};

  localparam logic [4:0] CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] CH_REF_LOW  = 5'h1E;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;

  // Converter clock cycles per conversion, counted from the prescaler restart
  localparam logic [4:0] CONV_CYCLES = 5'h10;
  localparam logic [4:0] CONV_LAST   = CONV_CYCLES - 5'h01;

endpackage

// File: testbench/acr_adc_control_props.sv
// Port checks of the converter control block.
// Assumes status/control at byte 0x15C and low result at 0x168.
`timescale 1ns/1ps
module acr_adc_control_props (
  // Clock and reset
  input wire logic                       CLK_I,
  input wire logic                       RESET_I,
  // APB
  input wire logic                       PSEL_I,
  input wire logic                       PENABLE_I,
  input wire logic                       PWRITE_I,
  input wire logic [acr_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [acr_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [acr_pkg::DATA_W-1:0] PRDATA_O,
  // Converter and interrupt
  input wire logic [4:0]                 CHANNEL_O,
  input wire logic                       POWER_DOWN_O,
  input wire logic                       CONV_ACTIVE_O,
  input wire logic                       CONV_TICK_O,
  input wire logic                       IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic acc;
  logic wr_scr;
  logic rd_scr;
  logic rd_lo;
  assign acc    = PSEL_I && PENABLE_I;
  assign wr_scr = acc && PWRITE_I && PADDR_I == 12'h15C;
  assign rd_scr = acc && !PWRITE_I && PADDR_I == 12'h15C;
  assign rd_lo  = acc && !PWRITE_I && PADDR_I == 12'h168;

  // ************************************************************
  // Assertions
  // ************************************************************
  chk_start_conv: assert property (wr_scr && PWDATA_I[4:0] != 5'h1F |=> CONV_ACTIVE_O)
    else $error("conversion did not start");
  chk_conv_length: assert property ($fell(CONV_ACTIVE_O) && !$past(wr_scr) |->
    $past(CONV_ACTIVE_O, 16)) else $error("conversion too short");
  chk_start_cause: assert property ($rose(CONV_ACTIVE_O) |-> $past(wr_scr))
    else $error("conversion without start");
  chk_power_off: assert property (POWER_DOWN_O == (CHANNEL_O == 5'h1F))
    else $error("power-off mismatch");
  chk_tick_in_conv: assert property (CONV_TICK_O |-> $past(CONV_ACTIVE_O))
    else $error("tick outside conversion");
  chk_irq_cause: assert property ($rose(IRQ_O) |-> $past(CONV_ACTIVE_O))
    else $error("interrupt without conversion end");
  chk_irq_write_drop: assert property (wr_scr && !CONV_ACTIVE_O |=> !IRQ_O)
    else $error("interrupt kept after write");
  chk_irq_read_drop: assert property (rd_lo && !CONV_ACTIVE_O |=> !IRQ_O)
    else $error("interrupt kept after read");
  chk_flag_hidden: assert property (rd_scr && IRQ_O |-> !PRDATA_O[7])
    else $error("flag visible with interrupts on");

  cover property (wr_scr && PWDATA_I[4:0] != 5'h1F);
  cover property ($rose(IRQ_O));
  cover property ($fell(CONV_ACTIVE_O));
endmodule

bind acr_adc_control acr_adc_control_props u_props (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .CHANNEL_O, .POWER_DOWN_O, .CONV_ACTIVE_O,
  .CONV_TICK_O, .IRQ_O);

// File: testbench/acr_adc_control_tb.sv
// Self-checking bench of the converter control block.
// Assumes the block, its package, the port checker and the core model.
`timescale 1ns/1ps
module acr_adc_control_tb;
  localparam logic [11:0] A_SCR = 12'h15C;
  localparam logic [11:0] A_CLK = 12'h160;
  localparam logic [11:0] A_HI  = 12'h164;
  localparam logic [11:0] A_LO  = 12'h168;
  localparam logic [11:0] A_S1  = 12'h16C;
  localparam logic [11:0] A_SC  = 12'h178;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, osc, pdown, active, irq;
  logic [9:0]  sample;
  logic [4:0]  chan;
  logic [4:0]  lsb = 5'h00;
  int          fail_count = 0;
  int          cmp_count = 0;

  always #12.5 clk = ~clk;

  acr_adc_control DUT (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .OSC_CLK_I(osc), .SAMPLE_RESULT_I(sample),
    .CHANNEL_O(chan), .POWER_DOWN_O(pdown), .CONV_ACTIVE_O(active), .CONV_TICK_O(),
    .IRQ_O(irq));
  acr_conv_model u_core (.clk_i(clk), .rst_i(rst), .chan_i(chan), .active_i(active), .lsb_i(lsb),
    .osc_o(osc), .sample_o(sample));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic cnt(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (active === 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask
  function automatic logic [15:0] place(input logic [1:0] m, input logic [9:0] s);
    case (m)
      2'h0: place = {8'h00, s[9:2]};
      2'h1: place = {6'h00, s};
      2'h2: place = {s, 6'h00};
      default: place = {~s[9], s[8:0], 6'h00};
    endcase
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rdc(A_SCR, 32'h1F);
    rdc(A_CLK, 32'h04);
    rdc(A_SC, 32'h00);
    chk(irq, 1'b0);
    chk(pdown, 1'b1);
    rdc(12'h17C, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_modes;
    int n;
    logic [15:0] e;
    wr(A_CLK, 8'h10);
    wr(A_SCR, 8'h83);
    rdc(A_SCR, 32'h03);
    cnt(n);
    for (int m = 0; m < 4; m++) begin
      lsb <= 5'h0B + 5'(m);
      wr(A_CLK, 8'h10 | 8'(m << 2));
      wr(A_SCR, 8'h83);
      cnt(n);
      rdc(A_SCR, 32'h83);
      wr(A_CLK, 8'h10 | 8'(m << 2));
      rdc(A_SCR, 32'h03);
      e = place(2'(m), {5'h03, lsb});
      rdc(A_HI, e[15:8]);
      rdc(A_LO, e[7:0]);
      chk(active, 1'b0);
    end
  endtask
  task automatic t_prescale;
    int n;
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int div [6] = '{1, 2, 4, 8, 16, 16};
    foreach (code[i]) begin
      wr(A_CLK, {code[i], 5'h14});
      wr(A_SCR, 8'h03);
      cnt(n);
      chk(n, 16 * div[i] + 1);
    end
    wr(A_SCR, 8'h03);
    wr(A_SCR, 8'h03);
    cnt(n);
    chk(n, 16 * 16 + 1);
    wr(A_CLK, 8'h04);
    wr(A_SCR, 8'h03);
    cnt(n);
    chk(n > 60 && n < 73, 1'b1);
    // oscillator divided by 8 keeps converter clock in range
    wr(A_CLK, 8'h64);
    wr(A_SCR, 8'h03);
    cnt(n);
    chk(n > 505 && n < 520, 1'b1);
  endtask
  task automatic t_lock;
    int n;
    logic [15:0] e;
    lsb <= 5'h0A;
    wr(A_CLK, 8'h18);
    wr(A_SCR, 8'h25);
    repeat (20) @(posedge clk);
    e = place(2'h2, {5'h05, 5'h0A});
    rdc(A_HI, e[15:8]);
    lsb <= 5'h13;
    repeat (40) @(posedge clk);
    rdc(A_LO, e[7:0]);
    repeat (40) @(posedge clk);
    e = place(2'h2, {5'h05, 5'h13});
    rdc(A_HI, e[15:8]);
    rdc(A_LO, e[7:0]);
    wr(A_SCR, 8'h05);
    cnt(n);
    rdc(A_LO, e[7:0]);
    rdc(A_SCR, 32'h05);
  endtask
  task automatic t_irq;
    int n;
    wr(A_CLK, 8'h10);
    wr(A_SCR, 8'h43);
    cnt(n);
    chk(irq, 1'b1);
    rdc(A_SCR, 32'h43);
    apb(1'b0, A_LO, 8'h00);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(A_SCR, 8'h43);
    cnt(n);
    chk(irq, 1'b1);
    wr(A_SCR, 8'h5F);
    @(posedge clk);
    chk(irq, 1'b0);
  endtask
  task automatic t_chan;
    logic [4:0] c [5] = '{5'h00, 5'h07, 5'h1D, 5'h1E, 5'h1F};
    foreach (c[i]) begin
      wr(A_SCR, {3'h0, c[i]});
      repeat (2) @(posedge clk);
      chk(chan, c[i]);
      chk(pdown, c[i] == 5'h1F);
    end
  endtask
  task automatic t_scan;
    lsb <= 5'h15;
    wr(A_CLK, 8'h10);
    // scan run with continuous mode clear
    wr(A_SC, 8'h07);
    wr(A_SCR, 8'h1F);
    repeat (70) @(posedge clk);
    wr(A_SCR, 8'h1F);
    repeat (70) @(posedge clk);
    rdc(A_LO, {5'h00, 5'h15} >> 2);
    for (int k = 1; k < 4; k++) begin
      rdc(A_S1 + 12'(4 * k - 4), {5'(k), 5'h15} >> 2);
    end
    wr(A_SC, 8'h00);
    wr(A_SCR, 8'h1F);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_prescale();
    t_lock();
    t_irq();
    t_chan();
    t_scan();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    print_verdict();
  end
endmodule

// File: testbench/acr_conv_model.sv
// Converter core stand-in: oscillator clock and sample source.
// Assumes the bench sets the low sample bits; the channel comes from the block.
`timescale 1ns/1ps
module acr_conv_model (
  // Clock
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Block side
  input  wire logic [4:0] chan_i,
  input  wire logic       active_i,
  input  wire logic [4:0] lsb_i,
  output logic            osc_o,
  output logic [9:0]      sample_o
);
  logic [1:0] div_r;

  // oscillator at 10 MHz, well above 1 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign osc_o = div_r[1];

  // Sample valid only while converting, inverted otherwise
  assign sample_o = active_i ? {chan_i, lsb_i} : ~{chan_i, lsb_i};
endmodule
